/* hdl/comm_object_dictionary.sv */
// communication object dictionary with store/restore and mirrored objects
`timescale 1ns/100ps
`include "comm_od_params.svh"
module comm_object_dictionary #(
    parameter int          NOBJ      = 2,
    parameter logic [31:0] MAKER     = 32'h00001234, // arbitrary value
    parameter logic [31:0] PRODUCT   = 32'h00000001, // arbitrary value
    parameter logic [31:0] REVISION  = 32'h00000001,
    parameter logic [31:0] SERIAL    = 32'h00000001,
    parameter logic [31:0] DEF_RPM   = 32'h00000000,
    parameter logic [127:0] NAME_STR = "DRIVE UNIT",
    parameter int          NAME_LEN  = 10,
    parameter logic [127:0] HW_STR   = "HW 1",
    parameter int          HW_LEN    = 4,
    parameter logic [127:0] SW_STR   = "1.0.0",
    parameter int          SW_LEN    = 5
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // sdo access request
    input  wire logic                  sdo_req,
    input  wire logic                  sdo_write,
    input  wire logic [15:0]           sdo_index,
    input  wire logic [7:0]            sdo_subindex,
    input  wire logic [7:0]            sdo_char,
    input  wire logic [31:0]           sdo_wdata,
    // sdo answer
    output logic                       sdo_done_ff,
    output logic                       sdo_abort_ff,
    output logic [31:0]                sdo_rdata_ff,
    // drive state
    input  wire logic                  fault_active,
    input  wire logic [7:0]            motor_pole_pair_count,
    // mirrored profile objects and local parameters
    input  wire logic                  obj_wr,
    input  wire logic [$clog2(NOBJ)-1:0] obj_sel,
    input  wire logic [31:0]           obj_data,
    input  wire logic                  local_wr,
    input  wire logic [NOBJ-1:0][31:0] local_par,
    // non-volatile storage
    input  wire logic                  nv_valid,
    input  wire logic [NOBJ-1:0][31:0] nv_rd_data,
    output logic                       nv_wr_ff,
    output logic                       nv_clr_ff,
    output logic [NOBJ-1:0][31:0]      nv_wr_data_ff,
    output logic                       comm_store_ff,
    output logic                       comm_restore_ff,
    // active drive parameters
    output logic [NOBJ-1:0][31:0]      par_ff
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // pole pairs come from data set 1 only, so all derived values agree
    function automatic logic [31:0] rpm_to_freq(input logic [31:0] rpm,
                                                input logic [7:0]  pp);
        logic [39:0] prod;
        prod = {8'h00, rpm} * {32'h0, pp};
        rpm_to_freq = 32'(prod / `RPM_PER_HZ);
    endfunction : rpm_to_freq

    // character i of a right-justified packed string, zero past its end
    function automatic logic [7:0] str_char(input logic [127:0] s,
                                            input int len,
                                            input logic [7:0] i);
        str_char = 8'h00;
        if (int'(i) < len)
            str_char = s[(len - 1 - int'(i)) * 8 +: 8];
    endfunction : str_char

    // ----------------------------------------------------------------
    // state and request decode
    // ----------------------------------------------------------------
    comm_od_pkg::od_state_t state_ff;
    logic [NOBJ-1:0][31:0]  obj_ff;
    logic                   take;
    logic                   is_store;
    logic                   is_rest;
    logic                   cmd_sub;
    logic                   key_ok;
    logic                   do_store;
    logic                   do_rest;
    logic                   app_grp;
    logic                   nxt_abort;
    logic [31:0]            nxt_rdata;

    // requests are ignored during the boot cycle
    assign take     = sdo_req && (state_ff == comm_od_pkg::ST_RUN);
    assign is_store = (sdo_index == `IDX_STORE);
    assign is_rest  = (sdo_index == `IDX_RESTORE);
    assign cmd_sub  = (sdo_subindex == `SUB_ALL) || (sdo_subindex == `SUB_COMM)
                      || (sdo_subindex == `SUB_APP);
    assign key_ok   = is_store ? (sdo_wdata == `KEY_SAVE)
                               : (sdo_wdata == `KEY_LOAD);
    assign app_grp  = (sdo_subindex != `SUB_COMM);
    assign do_store = take && sdo_write && is_store && cmd_sub && key_ok;
    assign do_rest  = take && sdo_write && is_rest && cmd_sub && key_ok;

    // power-on load lasts one cycle, then the dictionary serves requests
    always_ff @(posedge mclk)
    begin
        if (srst)
            state_ff <= comm_od_pkg::ST_BOOT;
        else
            state_ff <= comm_od_pkg::ST_RUN;
    end

    // ----------------------------------------------------------------
    // read data and abort decision
    // ----------------------------------------------------------------
    // every write except a keyed command aborts; unknown objects abort
    always_comb
    begin
        nxt_rdata = 32'h0;
        nxt_abort = 1'b0;
        unique case (sdo_index)
            `IDX_DEV_TYPE:
            begin
                nxt_rdata = {`MODE_BITS, `DEV_KIND, `PROFILE_NUM};
                nxt_abort = sdo_write || (sdo_subindex != `SUB_COUNT);
            end
            `IDX_FAULT:
            begin
                nxt_rdata = {24'h0, fault_active ? `FAULT_SET : `FAULT_NONE};
                nxt_abort = sdo_write || (sdo_subindex != `SUB_COUNT);
            end
            `IDX_NAME:
            begin
                nxt_rdata = {24'h0, str_char(NAME_STR, NAME_LEN, sdo_char)};
                nxt_abort = sdo_write || (sdo_subindex != `SUB_COUNT);
            end
            `IDX_HW_VER:
            begin
                nxt_rdata = {24'h0, str_char(HW_STR, HW_LEN, sdo_char)};
                nxt_abort = sdo_write || (sdo_subindex != `SUB_COUNT);
            end
            `IDX_SW_VER:
            begin
                nxt_rdata = {24'h0, str_char(SW_STR, SW_LEN, sdo_char)};
                nxt_abort = sdo_write || (sdo_subindex != `SUB_COUNT);
            end
            `IDX_STORE, `IDX_RESTORE:
            begin
                if (sdo_subindex == `SUB_COUNT)
                begin
                    nxt_rdata = {24'h0, `CMD_COUNT};
                    nxt_abort = sdo_write;
                end
                else if (cmd_sub)
                begin
                    nxt_rdata = `CMD_READBACK;
                    nxt_abort = sdo_write && !key_ok;
                end
                else
                    nxt_abort = 1'b1;
            end
            `IDX_IDENTITY:
            begin
                nxt_abort = sdo_write;
                unique case (sdo_subindex)
                    `SUB_COUNT:  nxt_rdata = {24'h0, `ID_COUNT};
                    `SUB_ALL:    nxt_rdata = MAKER;
                    `SUB_COMM:   nxt_rdata = PRODUCT;
                    `SUB_APP:    nxt_rdata = REVISION;
                    `SUB_SERIAL: nxt_rdata = SERIAL;
                    default:     nxt_abort = 1'b1;
                endcase
            end
            default: nxt_abort = 1'b1;
        endcase
    end

    // answer one cycle after the request is taken
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sdo_done_ff  <= 1'b0;
            sdo_abort_ff <= 1'b0;
            sdo_rdata_ff <= 32'h0;
        end
        else
        begin
            sdo_done_ff  <= take;
            sdo_abort_ff <= take && nxt_abort;
            sdo_rdata_ff <= (take && !nxt_abort && !sdo_write) ? nxt_rdata : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // store and restore commands
    // ----------------------------------------------------------------
    // storage strobes: app objects for sub 1 and 3, comm group for 1 and 2
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            nv_wr_ff        <= 1'b0;
            nv_clr_ff       <= 1'b0;
            comm_store_ff   <= 1'b0;
            comm_restore_ff <= 1'b0;
            nv_wr_data_ff   <= '0;
        end
        else
        begin
            nv_wr_ff        <= do_store && app_grp;
            nv_clr_ff       <= do_rest && app_grp;
            comm_store_ff   <= do_store && (sdo_subindex != `SUB_APP);
            comm_restore_ff <= do_rest && (sdo_subindex != `SUB_APP);
            if (do_store && app_grp)
                nv_wr_data_ff <= obj_ff;
        end
    end

    // ----------------------------------------------------------------
    // mirrored objects and active parameters
    // ----------------------------------------------------------------
    // restore beats an object write, which beats a local write
    always_ff @(posedge mclk)
    begin
        if (srst)
            obj_ff <= '0;
        else if (state_ff == comm_od_pkg::ST_BOOT)
            obj_ff <= nv_valid ? nv_rd_data : '0;
        else if (do_rest && app_grp)
        begin
            for (int k = 0; k < NOBJ; k++)
                obj_ff[k] <= DEF_RPM;
        end
        else if (obj_wr)
            obj_ff[obj_sel] <= obj_data;
    end

    // the saved copy decides at boot; a local change after save is lost
    always_ff @(posedge mclk)
    begin
        if (srst)
            par_ff <= '0;
        else if (state_ff == comm_od_pkg::ST_BOOT)
        begin
            for (int k = 0; k < NOBJ; k++)
                par_ff[k] <= nv_valid ? rpm_to_freq(nv_rd_data[k], motor_pole_pair_count)
                                      : local_par[k];
        end
        else if (do_rest && app_grp)
        begin
            for (int k = 0; k < NOBJ; k++)
                par_ff[k] <= rpm_to_freq(DEF_RPM, motor_pole_pair_count);
        end
        else if (obj_wr)
            par_ff[obj_sel] <= rpm_to_freq(obj_data, motor_pole_pair_count);
        else if (local_wr)
            par_ff <= local_par;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    dev_type_val_a: assert property (@(posedge mclk) disable iff (srst)
        $past(take) && !$past(sdo_write) && $past(sdo_index) == `IDX_DEV_TYPE
        && $past(sdo_subindex) == `SUB_COUNT |-> sdo_rdata_ff == 32'h002a0192)
        else $error("device type value wrong");

    fault_read_a: assert property (@(posedge mclk) disable iff (srst)
        take && !sdo_write && sdo_index == `IDX_FAULT && sdo_subindex == `SUB_COUNT
        |=> (sdo_rdata_ff != 32'h0) == $past(fault_active))
        else $error("fault indicator wrong");

    cmd_count_a: assert property (@(posedge mclk) disable iff (srst)
        take && !sdo_write && (is_store || is_rest) && sdo_subindex == `SUB_COUNT
        |=> sdo_rdata_ff == 32'h3 && !sdo_abort_ff)
        else $error("command count not 3");

    bad_store_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && is_store && sdo_wdata != `KEY_SAVE
        |=> sdo_abort_ff && !nv_wr_ff && !comm_store_ff)
        else $error("bad store key accepted");

    good_store_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && is_store && sdo_subindex == `SUB_APP && sdo_wdata == `KEY_SAVE
        |=> nv_wr_ff && !sdo_abort_ff && nv_wr_data_ff == $past(obj_ff))
        else $error("save key not stored");

    bad_restore_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && is_rest && sdo_wdata != `KEY_LOAD
        |=> sdo_abort_ff && !nv_clr_ff && obj_ff == $past(obj_ff))
        else $error("bad restore key accepted");

    ident_count_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_index == `IDX_IDENTITY && sdo_subindex == `SUB_COUNT
        |=> sdo_abort_ff == $past(sdo_write) && (sdo_abort_ff || sdo_rdata_ff == 32'h4))
        else $error("identity count wrong");

    boot_load_a: assert property (@(posedge mclk) disable iff (srst)
        state_ff == comm_od_pkg::ST_BOOT && nv_valid
        |=> par_ff[0] == rpm_to_freq($past(nv_rd_data[0]), $past(motor_pole_pair_count)))
        else $error("saved value not loaded");

    boot_local_a: assert property (@(posedge mclk) disable iff (srst)
        state_ff == comm_od_pkg::ST_BOOT && !nv_valid |=> par_ff == $past(local_par))
        else $error("local value not applied");

    rpm_conv_a: assert property (@(posedge mclk) disable iff (srst)
        state_ff == comm_od_pkg::ST_RUN && obj_wr && !do_rest
        |=> par_ff[$past(obj_sel)] == rpm_to_freq($past(obj_data), $past(motor_pole_pair_count)))
        else $error("rpm conversion wrong");

    // keyed commands on the application and communication groups
    good_restore_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && is_rest && sdo_subindex == `SUB_APP && sdo_wdata == `KEY_LOAD
        |=> nv_clr_ff && !sdo_abort_ff && obj_ff[0] == DEF_RPM)
        else $error("load key not restored");

    comm_store_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && is_store && sdo_subindex == `SUB_COMM && sdo_wdata == `KEY_SAVE
        |=> comm_store_ff && !nv_wr_ff && !sdo_abort_ff)
        else $error("comm store wrong");

    comm_restore_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && is_rest && sdo_subindex == `SUB_COMM && sdo_wdata == `KEY_LOAD
        |=> comm_restore_ff && !nv_clr_ff && !sdo_abort_ff)
        else $error("comm restore wrong");

    // the count entries are read only even when a valid key is written
    count_ro_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && (is_store || is_rest) && sdo_subindex == `SUB_COUNT
        |=> sdo_abort_ff && !nv_wr_ff && !nv_clr_ff)
        else $error("command count written");

    // the fixed objects refuse every write, whatever the subindex
    dev_type_ro_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && sdo_index == `IDX_DEV_TYPE |=> sdo_abort_ff && sdo_rdata_ff == 32'h0)
        else $error("device type written");

    fault_ro_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && sdo_index == `IDX_FAULT |=> sdo_abort_ff && sdo_rdata_ff == 32'h0)
        else $error("fault indicator written");

    string_ro_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && (sdo_index == `IDX_NAME || sdo_index == `IDX_HW_VER
        || sdo_index == `IDX_SW_VER) |=> sdo_abort_ff && sdo_rdata_ff == 32'h0)
        else $error("string object written");

    // string characters come back one byte at a time, upper bytes clear
    string_char_a: assert property (@(posedge mclk) disable iff (srst)
        take && !sdo_write && sdo_subindex == `SUB_COUNT && (sdo_index == `IDX_NAME
        || sdo_index == `IDX_HW_VER || sdo_index == `IDX_SW_VER)
        |=> !sdo_abort_ff && sdo_rdata_ff[31:8] == 24'h0)
        else $error("string char not one byte");

    ident_ro_a: assert property (@(posedge mclk) disable iff (srst)
        take && sdo_write && sdo_index == `IDX_IDENTITY |=> sdo_abort_ff)
        else $error("identity written");

endmodule : comm_object_dictionary

/* common/comm_od_params.svh */
// object indexes, subindexes, keys and fixed field values of the dictionary
`ifndef COMM_OD_PARAMS_SVH
`define COMM_OD_PARAMS_SVH
`define IDX_DEV_TYPE   16'h1000
`define IDX_FAULT      16'h1001
`define IDX_NAME       16'h1008
`define IDX_HW_VER     16'h1009
`define IDX_SW_VER     16'h100a
`define IDX_STORE      16'h1010
`define IDX_RESTORE    16'h1011
`define IDX_IDENTITY   16'h1018
`define SUB_COUNT      8'h00
`define SUB_ALL        8'h01
`define SUB_COMM       8'h02
`define SUB_APP        8'h03
`define SUB_SERIAL     8'h04
`define CMD_COUNT      8'h03
`define ID_COUNT       8'h04
`define KEY_SAVE       32'h65766173
`define KEY_LOAD       32'h64616f6c
`define PROFILE_NUM    16'h0192
`define DEV_KIND       8'h2a
`define MODE_BITS      8'h00
`define FAULT_NONE     8'h00
`define FAULT_SET      8'h01
`define CMD_READBACK   32'h00000001
`define RPM_PER_HZ     40'h000000003c
`endif

/* common/comm_od_pkg.sv */
// types shared by the communication object dictionary
package comm_od_pkg;
    typedef enum logic [1:0] {
        ST_BOOT = 2'b01,
        ST_RUN  = 2'b10
    } od_state_t;
endpackage : comm_od_pkg

/* test/nv_store_model.sv */
// non-volatile storage model standing behind the object dictionary
`timescale 1ns/100ps
module nv_store_model #(
    parameter int NOBJ = 2
) (
    // clock
    input  wire logic                  mclk,
    // storage commands from the dictionary
    input  wire logic                  nv_wr_ff,
    input  wire logic                  nv_clr_ff,
    input  wire logic [NOBJ-1:0][31:0] nv_wr_data_ff,
    // storage state seen by the dictionary
    output logic                       nv_valid,
    output logic [NOBJ-1:0][31:0]      nv_rd_data
);
    logic [NOBJ-1:0][31:0] mem_ff;

    // contents ignore srst: a reset stands for a power cycle
    initial
    begin
        nv_valid = 1'b0;
        mem_ff   = '0;
    end
    always @(posedge mclk)
    begin
        if (nv_wr_ff === 1'b1)
        begin
            mem_ff   <= nv_wr_data_ff;
            nv_valid <= 1'b1;
        end
        else if (nv_clr_ff === 1'b1)
            nv_valid <= 1'b0;
    end
    // no valid copy: show inverted contents so stale data cannot pass
    assign nv_rd_data = nv_valid ? mem_ff : ~mem_ff;
endmodule : nv_store_model

/* test/tb_top.sv */
// self-checking bench for the communication object dictionary
`timescale 1ns/100ps
`include "comm_od_params.svh"
module tb_top;
    localparam logic [31:0] MAKER = 32'h00005a5a; // arbitrary value
    localparam logic [31:0] DEF   = 32'h00000096;
    logic             mclk, srst, sdo_req, sdo_write, fault_active, obj_wr, obj_sel, local_wr;
    logic             sdo_done_ff, sdo_abort_ff, nv_valid, nv_wr_ff, nv_clr_ff;
    logic             comm_store_ff, comm_restore_ff;
    logic [15:0]      sdo_index;
    logic [7:0]       sdo_subindex, sdo_char, motor_pole_pair_count;
    logic [31:0]      sdo_wdata, obj_data, sdo_rdata_ff, bad;
    logic [1:0][31:0] local_par, nv_rd_data, nv_wr_data_ff, par_ff;
    logic [32:0]      exp_q[$];
    logic [32:0]      note;
    logic [15:0]      str_idx [3] = '{`IDX_NAME, `IDX_HW_VER, `IDX_SW_VER};
    logic [31:0]      id_val [4] = '{MAKER, 32'h00000011, 32'h00000022, 32'h00000033};
    int               fails, checked;

    comm_object_dictionary #(.MAKER(MAKER), .PRODUCT(32'h00000011), .REVISION(32'h00000022),
        .SERIAL(32'h00000033), .DEF_RPM(DEF), .NAME_STR("AB"), .NAME_LEN(2), .HW_STR("CD"),
        .HW_LEN(2), .SW_STR("EF"), .SW_LEN(2)) uut (.mclk, .srst, .sdo_req, .sdo_write,
        .sdo_index, .sdo_subindex, .sdo_char, .sdo_wdata, .sdo_done_ff, .sdo_abort_ff,
        .sdo_rdata_ff, .fault_active, .motor_pole_pair_count, .obj_wr, .obj_sel, .obj_data,
        .local_wr, .local_par, .nv_valid, .nv_rd_data, .nv_wr_ff, .nv_clr_ff, .nv_wr_data_ff,
        .comm_store_ff, .comm_restore_ff, .par_ff);
    nv_store_model #(.NOBJ(2)) nv (.mclk, .nv_wr_ff, .nv_clr_ff, .nv_wr_data_ff, .nv_valid,
        .nv_rd_data);

    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // one request pulse; returns in the cycle where the answer stands
    task automatic sdo(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [7:0] chr, input logic [31:0] wd, input logic ab,
                       input logic [31:0] rd);
        @(posedge mclk);
        #1;
        sdo_req      = 1'b1;
        sdo_write    = w;
        sdo_index    = idx;
        sdo_subindex = sub;
        sdo_char     = chr;
        sdo_wdata    = wd;
        exp_q.push_back({ab, rd});
        @(posedge mclk);
        #1;
        sdo_req = 1'b0;
    endtask : sdo

    // reset stands for a power cycle; returns just after the boot edge
    task automatic reset_run(input int n);
        srst = 1'b1;
        repeat (n) @(posedge mclk);
        #1;
        srst = 1'b0;
        @(posedge mclk);
        #1;
    endtask : reset_run

    task automatic obj_set(input logic sel, input logic [31:0] rpm, input logic [7:0] pp);
        @(posedge mclk);
        #1;
        motor_pole_pair_count = pp;
        obj_wr   = 1'b1;
        obj_sel  = sel;
        obj_data = rpm;
        @(posedge mclk);
        #1;
        obj_wr = 1'b0;
        chk(par_ff[sel], 32'((40'(rpm) * pp) / 60));
    endtask : obj_set

    // answer watcher: oldest note against each answer, sampled mid-cycle
    always @(negedge mclk)
    begin
        if (sdo_done_ff === 1'b1)
        begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_dead_beef;
            chk(32'(sdo_abort_ff), 32'(note[32]));
            chk(sdo_rdata_ff, note[31:0]);
        end
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        fails = 0;
        checked = 0;
        {sdo_req, sdo_write, fault_active, obj_wr, obj_sel, local_wr} = '0;
        {sdo_index, sdo_subindex, sdo_char, sdo_wdata, obj_data} = '0;
        void'($urandom(83));
        motor_pole_pair_count = 8'h02;
        local_par = {$urandom, $urandom};
        reset_run(10);
        chk(par_ff[0], local_par[0]);
        sdo(1'b0, `IDX_DEV_TYPE, `SUB_COUNT, 8'h00, 32'h0, 1'b0, 32'h002a0192);
        sdo(1'b1, `IDX_DEV_TYPE, `SUB_COUNT, 8'h00, 32'h1, 1'b1, 32'h0);
        sdo(1'b0, `IDX_FAULT, `SUB_COUNT, 8'h00, 32'h0, 1'b0, 32'h0);
        fault_active = 1'b1;
        sdo(1'b0, `IDX_FAULT, `SUB_COUNT, 8'h00, 32'h0, 1'b0, 32'(`FAULT_SET));
        fault_active = 1'($urandom_range(1));
        sdo(1'b0, `IDX_FAULT, `SUB_COUNT, 8'h00, 32'h0, 1'b0, 32'(fault_active));
        sdo(1'b1, `IDX_FAULT, `SUB_COUNT, 8'h00, 32'h0, 1'b1, 32'h0);
        fault_active = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            for (int c = 0; c < 3; c++)
                sdo(1'b0, str_idx[k], 8'h00, 8'(c), 32'h0, 1'b0,
                    (c < 2) ? 32'(8'h41 + 2 * k + c) : 32'h0);
            sdo(1'b1, str_idx[k], 8'h00, 8'h00, 32'h1, 1'b1, 32'h0);
        end
        sdo(1'b0, `IDX_STORE, `SUB_COUNT, 8'h00, 32'h0, 1'b0, 32'h3);
        sdo(1'b1, `IDX_STORE, `SUB_COUNT, 8'h00, `KEY_SAVE, 1'b1, 32'h0);
        sdo(1'b0, `IDX_RESTORE, `SUB_COUNT, 8'h00, 32'h0, 1'b0, 32'h3);
        sdo(1'b0, `IDX_IDENTITY, `SUB_COUNT, 8'h00, 32'h0, 1'b0, 32'h4);
        for (int s = 1; s < 5; s++)
        begin
            sdo(1'b0, `IDX_IDENTITY, 8'(s), 8'h00, 32'h0, 1'b0, id_val[s - 1]);
            sdo(1'b1, `IDX_IDENTITY, 8'(s), 8'h00, 32'h1, 1'b1, 32'h0);
        end
        for (int s = 1; s < 4; s++)
        begin
            sdo(1'b0, `IDX_STORE, 8'(s), 8'h00, 32'h0, 1'b0, `CMD_READBACK);
            sdo(1'b0, `IDX_RESTORE, 8'(s), 8'h00, 32'h0, 1'b0, `CMD_READBACK);
        end
        sdo(1'b0, `IDX_IDENTITY, 8'h05, 8'h00, 32'h0, 1'b1, 32'h0);
        sdo(1'b0, 16'h1002, 8'h00, 8'h00, 32'h0, 1'b1, 32'h0);
        repeat (4) obj_set(1'($urandom_range(1)), $urandom_range(60000),
                           8'($urandom_range(8, 1)));
        obj_set(1'b0, 32'd1140, 8'h02);
        bad = $urandom;
        if (bad == `KEY_SAVE || bad == `KEY_LOAD)
            bad = bad ^ 32'h1;
        for (int s = 1; s < 4; s++)
        begin
            sdo(1'b1, `IDX_STORE, 8'(s), 8'h00, bad, 1'b1, 32'h0);
            chk(32'({nv_wr_ff, comm_store_ff}), 32'h0);
            sdo(1'b1, `IDX_STORE, 8'(s), 8'h00, `KEY_SAVE, 1'b0, 32'h0);
            chk(32'({nv_wr_ff, comm_store_ff}), (s == 1) ? 32'h3 : (s == 2) ? 32'h1 : 32'h2);
        end
        chk(nv_wr_data_ff[0], 32'd1140);
        local_par[0] = $urandom;
        local_wr = 1'b1;
        @(posedge mclk);
        #1;
        local_wr = 1'b0;
        chk(par_ff[0], local_par[0]);
        reset_run(2);
        chk(par_ff[0], 32'd38);
        for (int s = 1; s < 4; s++)
        begin
            sdo(1'b1, `IDX_RESTORE, 8'(s), 8'h00, bad, 1'b1, 32'h0);
            chk(32'({nv_clr_ff, comm_restore_ff}), 32'h0);
            chk(par_ff[0], 32'd38);
        end
        for (int s = 2; s > 0; s--)
        begin
            sdo(1'b1, `IDX_RESTORE, 8'(2 * s - 1), 8'h00, `KEY_LOAD, 1'b0, 32'h0);
            chk(32'({nv_clr_ff, comm_restore_ff}), (s == 2) ? 32'h2 : 32'h3);
        end
        sdo(1'b1, `IDX_RESTORE, `SUB_COMM, 8'h00, `KEY_LOAD, 1'b0, 32'h0);
        chk(32'({nv_clr_ff, comm_restore_ff}), 32'h1);
        @(posedge mclk);
        #1;
        chk(par_ff[0], 32'((DEF * 2) / 60));
        obj_set(1'b0, 32'd1140, 8'h02);
        reset_run(2);
        chk(par_ff[0], local_par[0]);
        repeat (3) @(posedge mclk);
        chk(32'(exp_q.size()), 32'h0);
        give_verdict();
    end
endmodule : tb_top
